// ### core/rxc_chan_eval.sv
// Per-channel free buffer threshold evaluator
`timescale 1ns/1ps
`include "rxc_defs.svh"
module rxc_chan_eval (
	rxc_thr_if.eval thr
);
	import rxc_pkg::*;

	// Zero threshold only fires once the channel has run dry
	always_comb
	begin
		thr.filter_hit = (thr.free_count <= {8'h00, thr.low_thresh});
		thr.flow_hit = thr.flow_en &&
			(thr.free_count <= {8'h00, thr.flow_thresh});
	end
endmodule : rxc_chan_eval

// ### core/rxc_top.sv
// Receive unicast, frame length, buffer offset and threshold configuration
`timescale 1ns/1ps
`include "rxc_defs.svh"
module rxc_top (
	input wire logic CLOCK,
	input wire logic RESET_N,
	input wire logic [`RXC_ADDR_W-1:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [31:0] REG_RDATA,
	input wire logic RX_FLOW_EN,
	input wire logic [`RXC_NUM_CHAN*`RXC_FREE_W-1:0] FREE_COUNTS,
	input wire logic RX_SOP,
	input wire logic [`RXC_CHAN_W-1:0] RX_SOP_CHAN,
	input wire logic RX_EOP,
	input wire logic [`RXC_CHAN_W-1:0] RX_EOP_CHAN,
	input wire logic [`RXC_LEN_W-1:0] RX_EOP_BYTES,
	input wire logic [7:0] RX_EOP_BUFS,
	input wire logic RX_EOP_CRC_ERR,
	input wire logic RX_EOP_CODE_ERR,
	input wire logic RX_EOP_ALIGN_ERR,
	input wire logic RX_EOP_LOW_PRI,
	output rxc_pkg::rxc_chan_mask_t UNICAST_ACTIVE,
	output logic SOP_DESC_VALID,
	output logic [`RXC_CHAN_W-1:0] SOP_DESC_CHAN,
	output logic [`RXC_LEN_W-1:0] SOP_DESC_BUF_OFFSET,
	output logic [`RXC_LEN_W:0] SOP_DATA_FIRST_BYTE,
	output logic FRAME_STAT_VALID,
	output logic [`RXC_CHAN_W-1:0] FRAME_STAT_CHAN,
	output logic FRAME_LONG,
	output rxc_pkg::rxc_frame_class_t FRAME_CLASS,
	output logic FRAME_LOW_PRI_DROP,
	output logic [`RXC_NUM_CHAN-1:0] FLOW_CTRL_REQ,
	output logic FREE_DEC_VALID,
	output logic [`RXC_CHAN_W-1:0] FREE_DEC_CHAN,
	output logic [7:0] FREE_DEC_COUNT
);
	import rxc_pkg::*;

	rxc_chan_mask_t uni_en_q;
	rxc_chan_mask_t mac_gate_q;
	logic [`RXC_LEN_W-1:0] max_len_q;
	logic [`RXC_LEN_W-1:0] buf_ofs_q;
	rxc_thr_t low_thr_q;
	rxc_thr_t flow_thr_q [`RXC_NUM_CHAN];
	logic [31:0] rdata_d;
	logic [`RXC_NUM_CHAN-1:0] filter_hit;
	logic [`RXC_NUM_CHAN-1:0] flow_hit;
	logic wr_set;
	logic wr_clr;
	logic wr_high;
	logic wr_low;
	logic wr_flow;
	logic [`RXC_CHAN_W-1:0] wr_idx;
	logic rd_idx_flow;
	logic long_d;
	logic err_d;

	// Address decode; the channel index sits in word-address bits
	assign wr_idx = REG_ADDR[`RXC_OFF_IDX_MSB:`RXC_OFF_IDX_LSB];
	assign wr_set = REG_WR && (REG_ADDR == `RXC_OFF_UNI_SET);
	assign wr_clr = REG_WR && (REG_ADDR == `RXC_OFF_UNI_CLR);
	assign wr_high = REG_WR && (REG_ADDR == `RXC_OFF_MAC_HIGH);
	assign wr_low = REG_WR && REG_ADDR[1:0] == 2'b00 &&
		((REG_ADDR & `RXC_OFF_BLOCK_MASK) == `RXC_OFF_MAC_LOW0);
	assign rd_idx_flow = REG_ADDR[1:0] == 2'b00 &&
		((REG_ADDR & `RXC_OFF_BLOCK_MASK) == `RXC_OFF_FLOW_THR0);
	assign wr_flow = REG_WR && rd_idx_flow;

	// Stored unicast enables; one write per cycle so set and clear never meet
	always_ff @(posedge CLOCK or negedge RESET_N)
	begin
		if (!RESET_N)
			uni_en_q <= `RXC_RST_UNI;
		else if (wr_set)
			uni_en_q <= uni_en_q | REG_WDATA[7:0];
		else if (wr_clr)
			uni_en_q <= uni_en_q & ~REG_WDATA[7:0];
	end

	// Address-programming gate: low write closes, high write reopens
	always_ff @(posedge CLOCK or negedge RESET_N)
	begin
		if (!RESET_N)
			mac_gate_q <= `RXC_RST_GATE;
		else if (wr_low)
			mac_gate_q[wr_idx] <= 1'b0;
		else if (wr_high)
			mac_gate_q <= mac_gate_q | uni_en_q;
	end

	assign UNICAST_ACTIVE = uni_en_q & mac_gate_q;

	always_ff @(posedge CLOCK or negedge RESET_N)
	begin
		if (!RESET_N)
			max_len_q <= `RXC_RST_MAX_LEN;
		else if (REG_WR && REG_ADDR == `RXC_OFF_MAX_LEN)
			max_len_q <= REG_WDATA[15:0];
	end

	always_ff @(posedge CLOCK or negedge RESET_N)
	begin
		if (!RESET_N)
			buf_ofs_q <= `RXC_RST_BUF_OFS;
		else if (REG_WR && REG_ADDR == `RXC_OFF_BUF_OFS)
			buf_ofs_q <= REG_WDATA[15:0];
	end

	always_ff @(posedge CLOCK or negedge RESET_N)
	begin
		if (!RESET_N)
			low_thr_q <= `RXC_RST_THR;
		else if (REG_WR && REG_ADDR == `RXC_OFF_LOW_THR)
			low_thr_q <= REG_WDATA[7:0];
	end

	always_ff @(posedge CLOCK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			for (int i = 0; i < `RXC_NUM_CHAN; i++)
				flow_thr_q[i] <= `RXC_RST_THR;
		end
		else if (wr_flow)
			flow_thr_q[wr_idx] <= REG_WDATA[7:0];
	end

	// Read mux; unmapped and address-only words read zero
	always_comb
	begin
		rdata_d = 32'h0000_0000;
		if (REG_ADDR == `RXC_OFF_UNI_SET)
			rdata_d[7:0] = uni_en_q & mac_gate_q;
		else if (REG_ADDR == `RXC_OFF_UNI_CLR)
			rdata_d[7:0] = uni_en_q;
		else if (REG_ADDR == `RXC_OFF_MAX_LEN)
			rdata_d[15:0] = max_len_q;
		else if (REG_ADDR == `RXC_OFF_BUF_OFS)
			rdata_d[15:0] = buf_ofs_q;
		else if (REG_ADDR == `RXC_OFF_LOW_THR)
			rdata_d[7:0] = low_thr_q;
		else if (rd_idx_flow)
			rdata_d[7:0] = flow_thr_q[wr_idx];
	end

	always_ff @(posedge CLOCK or negedge RESET_N)
	begin
		if (!RESET_N)
			REG_RDATA <= 32'h0000_0000;
		else
			REG_RDATA <= REG_RD ? rdata_d : 32'h0000_0000;
	end

	// Threshold evaluators, one per channel
	genvar g;
	generate
		for (g = 0; g < `RXC_NUM_CHAN; g++)
		begin : g_chan
			rxc_thr_if thr ();
			assign thr.free_count =
				FREE_COUNTS[g*`RXC_FREE_W +: `RXC_FREE_W];
			assign thr.low_thresh = low_thr_q;
			assign thr.flow_thresh = flow_thr_q[g];
			assign thr.flow_en = RX_FLOW_EN;
			assign filter_hit[g] = thr.filter_hit;
			assign flow_hit[g] = thr.flow_hit;
			rxc_chan_eval u_eval (
				.thr (thr.eval)
			);
		end
	endgenerate

	always_ff @(posedge CLOCK or negedge RESET_N)
	begin
		if (!RESET_N)
			FLOW_CTRL_REQ <= '0;
		else
			FLOW_CTRL_REQ <= flow_hit;
	end

	// Descriptor offset fields; first data byte is numbered from one
	always_ff @(posedge CLOCK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			SOP_DESC_VALID <= 1'b0;
			SOP_DESC_CHAN <= '0;
			SOP_DESC_BUF_OFFSET <= '0;
			SOP_DATA_FIRST_BYTE <= '0;
		end
		else
		begin
			SOP_DESC_VALID <= RX_SOP;
			if (RX_SOP)
			begin
				SOP_DESC_CHAN <= RX_SOP_CHAN;
				SOP_DESC_BUF_OFFSET <= buf_ofs_q;
				SOP_DATA_FIRST_BYTE <= {1'b0, buf_ofs_q} + 17'h00001;
			end
		end
	end

	assign long_d = RX_EOP_BYTES > max_len_q;
	assign err_d = RX_EOP_CRC_ERR || RX_EOP_CODE_ERR || RX_EOP_ALIGN_ERR;

	// End-of-frame status and free buffer accounting
	always_ff @(posedge CLOCK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			FRAME_STAT_VALID <= 1'b0;
			FRAME_STAT_CHAN <= '0;
			FRAME_LONG <= 1'b0;
			FRAME_CLASS <= RXC_FC_NORMAL;
			FRAME_LOW_PRI_DROP <= 1'b0;
		end
		else
		begin
			FRAME_STAT_VALID <= RX_EOP;
			if (RX_EOP)
			begin
				FRAME_STAT_CHAN <= RX_EOP_CHAN;
				FRAME_LONG <= long_d;
				if (long_d && err_d)
					FRAME_CLASS <= RXC_FC_JABBER;
				else if (long_d)
					FRAME_CLASS <= RXC_FC_OVERSIZE;
				else
					FRAME_CLASS <= RXC_FC_NORMAL;
				FRAME_LOW_PRI_DROP <= RX_EOP_LOW_PRI &&
					filter_hit[RX_EOP_CHAN];
			end
		end
	end

	always_ff @(posedge CLOCK or negedge RESET_N)
	begin
		if (!RESET_N)
		begin
			FREE_DEC_VALID <= 1'b0;
			FREE_DEC_CHAN <= '0;
			FREE_DEC_COUNT <= '0;
		end
		else
		begin
			FREE_DEC_VALID <= RX_EOP;
			if (RX_EOP)
			begin
				FREE_DEC_CHAN <= RX_EOP_CHAN;
				FREE_DEC_COUNT <= RX_EOP_BUFS;
			end
		end
	end

	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (!RESET_N);

	property p_uni_set;
		wr_set |=> ((uni_en_q & $past(REG_WDATA[7:0])) ==
			$past(REG_WDATA[7:0]));
	endproperty
	a_uni_set: assert property (p_uni_set)
		else $error("set view did not set enable bits");

	property p_uni_clr;
		wr_clr |=> ((uni_en_q & $past(REG_WDATA[7:0])) == 8'h00) &&
			((uni_en_q & ~$past(REG_WDATA[7:0])) ==
			($past(uni_en_q) & ~$past(REG_WDATA[7:0])));
	endproperty
	a_uni_clr: assert property (p_uni_clr)
		else $error("clear view did not clear exactly the written bits");

	property p_low_disable;
		wr_low |=> !UNICAST_ACTIVE[$past(wr_idx)];
	endproperty
	a_low_disable: assert property (p_low_disable)
		else $error("low address write left unicast active");

	property p_high_enable;
		wr_high |=> ((UNICAST_ACTIVE & $past(uni_en_q)) ==
			$past(uni_en_q));
	endproperty
	a_high_enable: assert property (p_high_enable)
		else $error("high address write did not reopen enabled channels");

	property p_rd_clr;
		REG_RD && REG_ADDR == `RXC_OFF_UNI_CLR && !REG_WR
			|=> REG_RDATA == {24'h000000, $past(uni_en_q)};
	endproperty
	a_rd_clr: assert property (p_rd_clr)
		else $error("clear view read differs from stored enables");

	property p_rd_set;
		REG_RD && REG_ADDR == `RXC_OFF_UNI_SET
			|=> REG_RDATA == {24'h000000, $past(UNICAST_ACTIVE)};
	endproperty
	a_rd_set: assert property (p_rd_set)
		else $error("set view read is not the gated enables");

	property p_rd_reserved;
		$past(REG_RD) && $past(REG_ADDR) != `RXC_OFF_MAX_LEN &&
			$past(REG_ADDR) != `RXC_OFF_BUF_OFS |-> REG_RDATA[31:8] == 24'h0;
	endproperty
	a_rd_reserved: assert property (p_rd_reserved)
		else $error("reserved read bits not zero");

	property p_classify;
		RX_EOP |=> FRAME_STAT_VALID &&
			(FRAME_LONG == ($past(RX_EOP_BYTES) > $past(max_len_q))) &&
			(FRAME_CLASS == (!FRAME_LONG ? RXC_FC_NORMAL :
			($past(err_d) ? RXC_FC_JABBER : RXC_FC_OVERSIZE)));
	endproperty
	a_classify: assert property (p_classify)
		else $error("frame length class wrong");

	property p_sop_offset;
		RX_SOP |=> SOP_DESC_VALID && SOP_DESC_BUF_OFFSET == $past(buf_ofs_q)
			&& SOP_DATA_FIRST_BYTE == {1'b0, SOP_DESC_BUF_OFFSET} + 17'h1;
	endproperty
	a_sop_offset: assert property (p_sop_offset)
		else $error("descriptor offset not copied");

	property p_free_dec;
		RESET_N |=> FREE_DEC_VALID == $past(RX_EOP) && (!FREE_DEC_VALID ||
			(FREE_DEC_CHAN == $past(RX_EOP_CHAN) &&
			FREE_DEC_COUNT == $past(RX_EOP_BUFS)));
	endproperty
	a_free_dec: assert property (p_free_dec)
		else $error("free count decrement request wrong");

	property p_flow;
		RESET_N |=> FLOW_CTRL_REQ == $past(flow_hit) &&
			($past(RX_FLOW_EN) || FLOW_CTRL_REQ == 8'h00);
	endproperty
	a_flow: assert property (p_flow)
		else $error("flow request not from threshold compare");

	property p_max_len_rst;
		$rose(RESET_N) |-> max_len_q == `RXC_RST_MAX_LEN;
	endproperty
	a_max_len_rst: assert property (p_max_len_rst)
		else $error("maximum length not at reset value");
endmodule : rxc_top

// ### include/rxc_defs.svh
// Register map, field widths and reset values of the receive configuration
`ifndef RXC_DEFS_SVH
`define RXC_DEFS_SVH

`define RXC_NUM_CHAN 8
`define RXC_ADDR_W 8
`define RXC_CHAN_W 3
`define RXC_UNI_W 8
`define RXC_LEN_W 16
`define RXC_THR_W 8
`define RXC_FREE_W 16

`define RXC_OFF_UNI_SET 8'h00
`define RXC_OFF_UNI_CLR 8'h04
`define RXC_OFF_MAX_LEN 8'h08
`define RXC_OFF_BUF_OFS 8'h0c
`define RXC_OFF_LOW_THR 8'h10
`define RXC_OFF_FLOW_THR0 8'h20
`define RXC_OFF_MAC_HIGH 8'h40
`define RXC_OFF_MAC_LOW0 8'h60
`define RXC_OFF_BLOCK_MASK 8'he0
`define RXC_OFF_IDX_LSB 2
`define RXC_OFF_IDX_MSB 4

`define RXC_RST_UNI 8'h00
`define RXC_RST_GATE 8'h00
`define RXC_RST_MAX_LEN 16'h05ee
`define RXC_RST_BUF_OFS 16'h0000
`define RXC_RST_THR 8'h00

`endif

// ### include/rxc_pkg.sv
// Types shared by the receive configuration modules
package rxc_pkg;
	typedef enum logic [1:0] {
		RXC_FC_NORMAL = 2'b00,
		RXC_FC_OVERSIZE = 2'b01,
		RXC_FC_JABBER = 2'b10
	} rxc_frame_class_t;
	typedef logic [7:0] rxc_chan_mask_t;
	typedef logic [7:0] rxc_thr_t;
	typedef logic [15:0] rxc_free_t;
endpackage : rxc_pkg

// ### include/rxc_thr_if.sv
// Threshold comparison carrier between config core and channel evaluator
`timescale 1ns/1ps
interface rxc_thr_if;
	import rxc_pkg::*;
	rxc_free_t free_count;
	rxc_thr_t low_thresh;
	rxc_thr_t flow_thresh;
	logic flow_en;
	logic filter_hit;
	logic flow_hit;
	modport cfg (output free_count, output low_thresh, output flow_thresh,
		output flow_en, input filter_hit, input flow_hit);
	modport eval (input free_count, input low_thresh, input flow_thresh,
		input flow_en, output filter_hit, output flow_hit);
endinterface : rxc_thr_if

// ### tb/rxc_frame_src.sv
// Far-side model: frame source and free buffer pool
`timescale 1ns/1ps
module rxc_frame_src (
	input wire logic clock,
	output logic sop,
	output logic [2:0] sop_chan,
	output logic eop,
	output logic [2:0] eop_chan,
	output logic [15:0] eop_bytes,
	output logic [7:0] eop_bufs,
	output logic [2:0] eop_err,
	output logic eop_low_pri,
	output logic [127:0] free_counts,
	input wire logic dec_valid,
	input wire logic [2:0] dec_chan,
	input wire logic [7:0] dec_count
);
	logic [15:0] pool_q [8];
	initial
	begin
		sop = 1'b0;
		sop_chan = 3'h0;
		eop = 1'b0;
		eop_chan = 3'h0;
		eop_bytes = 16'h0;
		eop_bufs = 8'h0;
		eop_err = 3'h0;
		eop_low_pri = 1'b0;
		for (int i = 0; i < 8; i++)
			pool_q[i] = 16'h0;
	end
	always_comb
		for (int i = 0; i < 8; i++)
			free_counts[16*i+:16] = pool_q[i];
	// Host side of the pool: consume what each frame used
	always @(posedge clock)
		if (dec_valid)
			pool_q[dec_chan] <= pool_q[dec_chan] - 16'(dec_count);
	task automatic set_free(input logic [2:0] c, input logic [15:0] v);
		pool_q[c] <= v;
	endtask : set_free
	task automatic send_sop(input logic [2:0] c);
		@(posedge clock);
		sop <= 1'b1;
		sop_chan <= c;
		@(posedge clock);
		sop <= 1'b0;
		sop_chan <= ~c;
	endtask : send_sop
	// Fields go to junk once the strobe drops, never hold stale values
	task automatic send_eop(input logic [2:0] c, input logic [15:0] b,
		input logic [7:0] n, input logic [2:0] e, input logic lp);
		@(posedge clock);
		eop <= 1'b1;
		eop_chan <= c;
		eop_bytes <= b;
		eop_bufs <= n;
		eop_err <= e;
		eop_low_pri <= lp;
		@(posedge clock);
		eop <= 1'b0;
		eop_chan <= ~c;
		eop_bytes <= ~b;
		eop_bufs <= ~n;
		eop_err <= ~e;
		eop_low_pri <= ~lp;
	endtask : send_eop
endmodule : rxc_frame_src

// ### tb/tb_rxc_top.sv
// Self-checking bench for the receive configuration block
`timescale 1ns/1ps
module tb_rxc_top;
	import rxc_pkg::*;
	logic clock, reset_n, reg_wr, reg_rd, flow_en;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, rd_v;
	logic [31:0] reg_rdata;
	logic sop, eop, eop_lp, sd_valid, fs_valid, long_f, drop, fd_valid;
	logic [2:0] sop_ch, eop_ch, eop_err, sd_ch, fs_ch, fd_ch;
	logic [15:0] eop_bytes, sd_ofs;
	logic [16:0] sd_first;
	logic [7:0] eop_bufs, fd_cnt, flow_req;
	logic [127:0] free_counts;
	rxc_chan_mask_t uni_act;
	rxc_frame_class_t fclass;
	int err_count = 0;
	int n_checks = 0;
	logic [15:0] fb [6] = '{16'd100, 16'd101, 16'd101, 16'd101, 16'd101,
		16'd100};
	logic [2:0] fe [6] = '{3'b000, 3'b000, 3'b001, 3'b010, 3'b100, 3'b001};
	logic [1:0] fcl [6] = '{RXC_FC_NORMAL, RXC_FC_OVERSIZE, RXC_FC_JABBER,
		RXC_FC_JABBER, RXC_FC_JABBER, RXC_FC_NORMAL};
	rxc_top dut_u (.CLOCK(clock), .RESET_N(reset_n), .REG_ADDR(reg_addr),
		.REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd),
		.REG_RDATA(reg_rdata), .RX_FLOW_EN(flow_en),
		.FREE_COUNTS(free_counts), .RX_SOP(sop), .RX_SOP_CHAN(sop_ch),
		.RX_EOP(eop), .RX_EOP_CHAN(eop_ch), .RX_EOP_BYTES(eop_bytes),
		.RX_EOP_BUFS(eop_bufs), .RX_EOP_CRC_ERR(eop_err[0]),
		.RX_EOP_CODE_ERR(eop_err[1]), .RX_EOP_ALIGN_ERR(eop_err[2]),
		.RX_EOP_LOW_PRI(eop_lp), .UNICAST_ACTIVE(uni_act),
		.SOP_DESC_VALID(sd_valid), .SOP_DESC_CHAN(sd_ch),
		.SOP_DESC_BUF_OFFSET(sd_ofs), .SOP_DATA_FIRST_BYTE(sd_first),
		.FRAME_STAT_VALID(fs_valid), .FRAME_STAT_CHAN(fs_ch),
		.FRAME_LONG(long_f), .FRAME_CLASS(fclass),
		.FRAME_LOW_PRI_DROP(drop), .FLOW_CTRL_REQ(flow_req),
		.FREE_DEC_VALID(fd_valid), .FREE_DEC_CHAN(fd_ch),
		.FREE_DEC_COUNT(fd_cnt));
	rxc_frame_src src_u (.clock(clock), .sop(sop), .sop_chan(sop_ch),
		.eop(eop), .eop_chan(eop_ch), .eop_bytes(eop_bytes),
		.eop_bufs(eop_bufs), .eop_err(eop_err), .eop_low_pri(eop_lp),
		.free_counts(free_counts), .dec_valid(fd_valid), .dec_chan(fd_ch),
		.dec_count(fd_cnt));
	always #5 clock = ~clock;
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask : wr
	// Data stand only in the cycle after the strobe
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clock);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask : rchk
	task tally_and_finish;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : tally_and_finish
	initial
	begin
		#200000;
		err_count++;
		tally_and_finish;
	end
	initial
	begin
		clock = 1'b0;
		reset_n = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 32'h0;
		flow_en = 1'b0;
		repeat (4) @(posedge clock);
		reset_n <= 1'b1;
		rchk(8'h08, 32'h000005ee);
		rchk(8'h04, 32'h0);
		rchk(8'h0c, 32'h0);
		rchk(8'h10, 32'h0);
		$display("test reset done");
		wr(8'h00, 32'hffffffa5);
		rchk(8'h04, 32'h000000a5);
		wr(8'h04, 32'hffffff21);
		rchk(8'h04, 32'h00000084);
		wr(8'h00, 32'h0);
		rchk(8'h04, 32'h00000084);
		rchk(8'h00, 32'h0);
		wr(8'h40, 32'h0);
		#1;
		chk({24'h0, uni_act}, 32'h00000084);
		rchk(8'h00, 32'h00000084);
		wr(8'h68, 32'h0);
		rchk(8'h00, 32'h00000080);
		rchk(8'h04, 32'h00000084);
		rchk(8'hfc, 32'h0);
		$display("test unicast done");
		wr(8'h0c, 32'hffff000f);
		rchk(8'h0c, 32'h0000000f);
		for (int c = 0; c < 8; c += 7)
		begin
			src_u.send_sop(3'(c));
			#1;
			chk(sd_valid, 1'b1);
			chk(sd_ch, 32'(c));
			chk(sd_ofs, 32'd15);
			chk(sd_first, 32'd16);
		end
		wr(8'h0c, 32'h0);
		src_u.send_sop(3'd3);
		#1;
		chk(sd_first, 32'd1);
		$display("test offset done");
		wr(8'h08, 32'hffff0064);
		rchk(8'h08, 32'h00000064);
		for (int i = 0; i < 6; i++)
		begin
			src_u.send_eop(3'(i), fb[i], 8'(i + 1), fe[i], 1'b0);
			#1;
			chk(fs_valid, 1'b1);
			chk(fs_ch, 32'(i));
			chk(long_f, 32'(i > 0 && i < 5));
			chk(fclass, 32'(fcl[i]));
			chk(fd_valid, 1'b1);
			chk(fd_ch, 32'(i));
			chk(fd_cnt, 32'(i + 1));
		end
		$display("test frame class done");
		wr(8'h10, 32'hffffff05);
		rchk(8'h10, 32'h00000005);
		for (int i = 0; i < 8; i++)
			wr(8'h20 + 8'(4 * i), {24'hffffff, 8'(i)});
		for (int i = 0; i < 8; i++)
			rchk(8'h20 + 8'(4 * i), 32'(i));
		for (int i = 0; i < 8; i++)
			src_u.set_free(3'(i), (i == 0) ? 16'd0 : (i == 1) ? 16'd6 :
				(i == 5) ? 16'd5 : 16'd4);
		@(posedge clock);
		flow_en <= 1'b1;
		repeat (3) @(posedge clock);
		#1;
		chk(flow_req, 32'h000000f1);
		src_u.send_eop(3'd5, 16'd64, 8'd0, 3'b000, 1'b1);
		#1;
		chk(drop, 1'b1);
		src_u.send_eop(3'd1, 16'd64, 8'd0, 3'b000, 1'b1);
		#1;
		chk(drop, 1'b0);
		@(posedge clock);
		flow_en <= 1'b0;
		repeat (3) @(posedge clock);
		#1;
		chk(flow_req, 32'h0);
		wr(8'h10, 32'h0);
		src_u.send_eop(3'd2, 16'd64, 8'd0, 3'b000, 1'b1);
		#1;
		chk(drop, 1'b0);
		src_u.send_eop(3'd0, 16'd64, 8'd0, 3'b000, 1'b1);
		#1;
		chk(drop, 1'b1);
		$display("test thresholds done");
		tally_and_finish;
	end
endmodule : tb_rxc_top
